//--- logic/adcs_clear_source.sv
// alarm-driven dac clear source select register bank with axi4-lite slave
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "adcs_regs.svh"
module adcs_clear_source
    import adcs_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] alarm_flags,
    output logic [11:0]      dac_clear
);
    // alarm flags arrive from detector logic on aclk, so no synchroniser
    adcs_state_s st_reg;    // all state
    adcs_state_s st_next;   // next state
    logic [11:0] clr_req;   // combinational clear request
    logic        any_sel;   // some non-overtemp source selected and flagged
    logic        ovt_hit;   // overtemp selected and flagged
    logic [15:0] hits;      // per-source select and flag
    logic [15:0] wr_mask;   // byte lanes of the held write, low half only
    logic [15:0] wr_word;   // low half of the held write data

    // ready strobes: accept while the channel is not yet held and no response waits
    assign s_axi_awready = st_reg.bus.awdone == 1'b0 && st_reg.bus.bvalid == 1'b0 ? 1'b1 : 1'b0;
    assign s_axi_wready  = st_reg.bus.wdone == 1'b0 && st_reg.bus.bvalid == 1'b0 ? 1'b1 : 1'b0;
    assign s_axi_arready = ~st_reg.bus.rvalid;
    assign s_axi_bvalid  = st_reg.bus.bvalid;
    assign s_axi_bresp   = st_reg.bus.bresp;
    assign s_axi_rvalid  = st_reg.bus.rvalid;
    assign s_axi_rresp   = st_reg.bus.rresp;
    assign s_axi_rdata   = st_reg.bus.rdata;
    assign dac_clear     = st_reg.dac_clear;
    // strobes widened to a bit mask so one masked merge serves both registers
    assign wr_mask       = {{8{st_reg.bus.wstrb[1]}}, {8{st_reg.bus.wstrb[0]}}};
    assign wr_word       = st_reg.bus.wdata[15:0];

    // clear request per dac
    always_comb begin
        hits    = st_reg.src_sel & st_reg.flags & `ADCS_SRC_SEL_MASK;
        ovt_hit = hits[`ADCS_BIT_OVERTEMP];
        any_sel = |hits[14:3];
    end

    // one term per dac: enable gates normal sources, overtemp bypasses the enable
    genvar g;
    generate
        for (g = 0; g < `ADCS_NUM_DAC; g++) begin : g_dac
            assign clr_req[g] = (st_reg.aclr_en[`ADCS_BIT_DAC0 + g] & any_sel) | ovt_hit;
        end
    endgenerate

    // next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.flags = alarm_flags;
        // held every cycle the request stands; no mode or sync-load term gates it
        st_next.dac_clear = clr_req;
        // write address and data may come in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.bus.awdone = 1'b1;
            st_next.bus.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.bus.wdone = 1'b1;
            st_next.bus.wdata = s_axi_wdata;
            st_next.bus.wstrb = s_axi_wstrb;
        end
        // commit once both halves are held
        if (st_reg.bus.awdone && st_reg.bus.wdone) begin
            st_next.bus.awdone = 1'b0;
            st_next.bus.wdone  = 1'b0;
            st_next.bus.bvalid = 1'b1;
            st_next.bus.bresp  = `ADCS_RESP_OKAY;
            unique case ({st_reg.bus.awaddr[7:2], 2'b00})
                `ADCS_SRC_SEL_ADDR: begin
                    // reserved bits masked out so they stay zero
                    st_next.src_sel = (st_reg.src_sel & ~wr_mask) | (wr_word & wr_mask & `ADCS_SRC_SEL_MASK);
                end
                `ADCS_ACLR_EN_ADDR: begin
                    // unused enable bits kept at zero as well
                    st_next.aclr_en = (st_reg.aclr_en & ~wr_mask) | (wr_word & wr_mask & `ADCS_ACLR_EN_MASK);
                end
                `ADCS_CONTROL_ADDR: begin
                    if (st_reg.bus.wstrb[0])
                        st_next.manual = st_reg.bus.wdata[0];
                end
                `ADCS_FLAGS_ADDR, `ADCS_CLEAR_ADDR: begin
                    // read-only words, write accepted and dropped
                end
                default: st_next.bus.bresp = `ADCS_RESP_SLVERR;
            endcase
        end
        if (st_reg.bus.bvalid && s_axi_bready)
            st_next.bus.bvalid = 1'b0;
        // reads answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.bus.rvalid = 1'b1;
            st_next.bus.rresp  = `ADCS_RESP_OKAY;
            st_next.bus.rdata  = 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `ADCS_SRC_SEL_ADDR: st_next.bus.rdata[15:0] = st_reg.src_sel & `ADCS_SRC_SEL_MASK;
                `ADCS_ACLR_EN_ADDR: st_next.bus.rdata[15:0] = st_reg.aclr_en & `ADCS_ACLR_EN_MASK;
                `ADCS_FLAGS_ADDR:   st_next.bus.rdata[15:0] = st_reg.flags;
                `ADCS_CLEAR_ADDR:   st_next.bus.rdata[11:0] = st_reg.dac_clear;
                `ADCS_CONTROL_ADDR: st_next.bus.rdata[0]    = st_reg.manual;
                default:            st_next.bus.rresp = `ADCS_RESP_SLVERR;
            endcase
        end else if (st_reg.bus.rvalid && s_axi_rready) begin
            st_next.bus.rvalid = 1'b0;
        end
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg         <= '0;
            st_reg.src_sel <= `ADCS_SRC_SEL_RST;
            st_reg.aclr_en <= `ADCS_ACLR_EN_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // checks
    reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.src_sel[15] == 1'b0 && st_reg.src_sel[1:0] == 2'b00)
        else $error("reserved select bits not zero");
    reset_value_a: assert property (@(posedge aclk) $rose(aresetn) |-> st_reg.src_sel == 16'h0004)
        else $error("select reset value wrong");
    overtemp_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg.src_sel[2] && st_reg.flags[2]) |=> dac_clear == 12'hFFF)
        else $error("overtemp did not clear all dacs");
    unselected_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ((st_reg.src_sel & st_reg.flags & 16'h7FFC) == 16'h0000) |=> dac_clear == 12'h000)
        else $error("clear without selected alarm");
    enable_gates_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!(st_reg.src_sel[2] && st_reg.flags[2]) && st_reg.aclr_en[3] == 1'b0) |=> !dac_clear[0])
        else $error("dac0 cleared without enable");
    input0_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg.src_sel[14] && st_reg.flags[14] && st_reg.aclr_en[14]) |=> dac_clear[11])
        else $error("input0 alarm did not clear dac11");
    hold_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg.src_sel[10] && st_reg.flags[10] && st_reg.aclr_en[3])[*3] |=> dac_clear[0])
        else $error("clear not held");
    read_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    cov_overtemp: cover property (@(posedge aclk) disable iff (!aresetn) st_reg.flags[2] && dac_clear == 12'hFFF);
    cov_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
    cov_partial: cover property (@(posedge aclk) disable iff (!aresetn) dac_clear != 12'h000 && dac_clear != 12'hFFF);
endmodule

//--- pkg/adcs_regs.svh
// register offsets, field positions and reset values for the alarm clear source block
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH
`define ADCS_SRC_SEL_IDX     8'h53
`define ADCS_SRC_SEL_ADDR    8'h4C
`define ADCS_SRC_SEL_RST     16'h0004
`define ADCS_SRC_SEL_MASK    16'h7FFC
`define ADCS_ACLR_EN_IDX     8'h54
`define ADCS_ACLR_EN_ADDR    8'h50
`define ADCS_ACLR_EN_RST     16'h0000
`define ADCS_ACLR_EN_MASK    16'h7FF8
`define ADCS_FLAGS_ADDR      8'h60
`define ADCS_CLEAR_ADDR      8'h64
`define ADCS_CONTROL_ADDR    8'h68
`define ADCS_BIT_OVERTEMP    2
`define ADCS_BIT_DAC0        3
`define ADCS_NUM_DAC         12
`define ADCS_RESP_OKAY       2'h0
`define ADCS_RESP_SLVERR     2'h2
`endif

//--- pkg/adcs_pkg.sv
// types shared by the alarm clear source block
package adcs_pkg;
    // alarm flags in source-select bit order, bits 14..2
    typedef logic [15:0] adcs_word_t;
    typedef struct packed {
        logic        awdone;     // write address held
        logic        wdone;      // write data held
        logic [7:0]  awaddr;     // captured write address
        logic [31:0] wdata;      // captured write data
        logic [3:0]  wstrb;      // captured strobes
        logic        bvalid;     // write response pending
        logic [1:0]  bresp;      // write response code
        logic        rvalid;     // read data pending
        logic [1:0]  rresp;      // read response code
        logic [31:0] rdata;      // read data
    } adcs_bus_s;
    typedef struct packed {
        adcs_bus_s   bus;        // bus slave state
        adcs_word_t  src_sel;    // alarm source select
        adcs_word_t  aclr_en;    // per-dac auto clear enables
        adcs_word_t  flags;      // registered alarm flags
        logic [11:0] dac_clear;  // registered clear outputs
        logic        manual;     // operating mode bit, informative only
    } adcs_state_s;
endpackage

//--- tb/adcs_clear_source_tb.sv
// self-checking bench for the alarm clear source register bank
`timescale 1ns/1ps
`include "adcs_regs.svh"
module adcs_clear_source_tb import adcs_pkg::*;;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, rd;
    adcs_word_t  alarm_flags = 16'h0000;
    adcs_word_t  s, e, f;
    logic [11:0] dac_clear;
    int          mismatches = 0;
    int          tests_run = 0;
    // 20 MHz clock
    always #25 aclk = ~aclk;
    adcs_clear_source uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .alarm_flags(alarm_flags), .dac_clear(dac_clear));
    // expected clear outputs: overtemp overrides the enables
    function automatic logic [11:0] want(input adcs_word_t sel, input adcs_word_t en, input adcs_word_t fl);
        if (sel[2] & fl[2]) return 12'hFFF;
        return (|(sel & fl & 16'h7FF8)) ? en[14:3] : 12'h000;
    endfunction
    // verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            mismatches++;
        end
    endtask
    // both halves offered together, each dropped once taken; bready held until bvalid
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) begin
            mismatches++;
            finish_test();
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) begin
            mismatches++;
            finish_test();
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // program select and enables, raise flags, sample after the two-edge latency
    task automatic run_case(input adcs_word_t sel, input adcs_word_t en, input adcs_word_t fl);
        axi_write(`ADCS_SRC_SEL_ADDR, {16'h0, sel}, rs);
        axi_write(`ADCS_ACLR_EN_ADDR, {16'h0, en}, rs);
        alarm_flags <= fl;
        repeat (2) @(posedge aclk);
        #1;
    endtask
    initial begin
        void'($urandom(32'hD7D4));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`ADCS_SRC_SEL_ADDR, rd, rs);
        check(rd, 32'h0000_0004);
        check({30'h0, rs}, {30'h0, `ADCS_RESP_OKAY});
        axi_read(`ADCS_ACLR_EN_ADDR, rd, rs);
        check(rd, 32'h0);
        axi_write(`ADCS_SRC_SEL_ADDR, 32'hFFFF_FFFF, rs);
        axi_read(`ADCS_SRC_SEL_ADDR, rd, rs);
        check(rd, 32'h0000_7FFC);
        // unmapped place refused with an error code
        axi_write(8'h7C, 32'hFFFF_FFFF, rs);
        check({30'h0, rs}, {30'h0, `ADCS_RESP_SLVERR});
        axi_read(8'h7C, rd, rs);
        check({30'h0, rs}, {30'h0, `ADCS_RESP_SLVERR});
        $display("test registers done");
        // each non-overtemp source alone, then every other source selected but this one
        for (int b = 3; b < 15; b++) begin
            e = 16'($urandom) | 16'h0008;
            run_case(16'h1 << b, e, 16'h1 << b);
            if (b > 8) check({20'h0, dac_clear}, {20'h0, e[14:3]});
            else check({20'h0, dac_clear}, {20'h0, e[14:3]});
            run_case(16'h7FFC ^ (16'h1 << b), e, 16'h1 << b);
            check({20'h0, dac_clear}, 32'h0);
        end
        $display("test single sources done");
        // overtemp ignores enables, and the clear holds while the flag stays
        run_case(16'h0004, 16'h0000, 16'h0004);
        check({20'h0, dac_clear}, 32'h0000_0FFF);
        repeat (8) @(posedge aclk);
        check({20'h0, dac_clear}, 32'h0000_0FFF);
        run_case(16'h0000, 16'h7FF8, 16'h0004);
        check({20'h0, dac_clear}, 32'h0);
        $display("test overtemp done");
        // random mixes, second half with the mode bit set
        for (int i = 0; i < 40; i++) begin
            if (i == 20) axi_write(`ADCS_CONTROL_ADDR, 32'h1, rs);
            s = 16'($urandom);
            e = 16'($urandom);
            f = 16'($urandom) & 16'($urandom);
            run_case(s, e, f);
            check({20'h0, dac_clear}, {20'h0, want(s, e, f)});
        end
        $display("test random done");
        finish_test();
    end
endmodule
